// ===== ssrc_cfg.svh
// Constants of the serial sleep and reset control link
`ifndef SSRC_CFG_SVH
`define SSRC_CFG_SVH
// System clock period in ns
`define SSRC_CLK_NS        10
// Opcodes
`define SSRC_OP_ENTER      8'hB9
`define SSRC_OP_EXIT       8'hAB
`define SSRC_OP_SOFT_RESET_CMD       8'h99
// Times in ns
`define SSRC_T_ENTRY_NS    3000
`define SSRC_T_EXIT_NS     3000
`define SSRC_T_WAKE_NS     1000
`define SSRC_T_GAP_RD_NS   20
`define SSRC_T_GAP_REG_NS  5000
`define SSRC_T_GAP_ARR_NS  280
`define SSRC_T_RSTPH_NS    1000
`define SSRC_T_HWRST_NS    450000
`define SSRC_T_SOFT_RESET_CMD_NS     50000
// Link framing
`define SSRC_SCK_HALF      8
`define SSRC_CNT_W         8
`define SSRC_BYTE_BITS     8'h08
`define SSRC_NO_BITS       8'h00
`define SSRC_JEDEC_PAT     4'h5
`define SSRC_JEDEC_PRIOR   3'h3
`define SSRC_RST_LAST_PH   3'h7
`define SSRC_EVAL_WAIT     2'h3
`define SSRC_EVAL_NOW      2'h1
`endif

// ===== ssrc_pkg.sv
// Types and cycle helpers shared by both link ends
package ssrc_pkg;
	`include "ssrc_cfg.svh"

	// Device power and reset states
	typedef enum logic [5:0] {
		D_ACTIVE   = 6'h01,
		D_ENTERING = 6'h02,
		D_SLEEP    = 6'h04,
		D_WAKING   = 6'h08,
		D_SOFT_RESET_CMD     = 6'h10,
		D_HWRST    = 6'h20
	} ssrc_dev_st_t;

	// Host sequencer states
	typedef enum logic [3:0] {
		H_IDLE  = 4'h1,
		H_SHIFT = 4'h2,
		H_PULSE = 4'h4,
		H_GAP   = 4'h8
	} ssrc_host_st_t;

	// Kinds of host transaction
	typedef enum logic [2:0] {
		K_READ, K_REG_WR, K_ARR_WR, K_SLEEP,
		K_WAKE_CMD, K_WAKE_PULSE, K_SOFT_RST, K_HW_RST
	} ssrc_kind_t;

	typedef logic [`SSRC_CNT_W-1:0] ssrc_cnt_t;

	// Least time to cycles, rounded up, never below one
	function automatic int unsigned ssrc_cyc_up(input int unsigned ns);
		int unsigned c;
		c = (ns + `SSRC_CLK_NS - 1) / `SSRC_CLK_NS;
		return (c == 0) ? 1 : c;
	endfunction

	// Longest time to cycles, rounded down, never below one
	function automatic int unsigned ssrc_cyc_dn(input int unsigned ns);
		int unsigned c;
		c = ns / `SSRC_CLK_NS;
		return (c == 0) ? 1 : c;
	endfunction

	// Binary to gray
	function automatic ssrc_cnt_t ssrc_b2g(input ssrc_cnt_t b);
		return b ^ (b >> 1);
	endfunction

	// Gray to binary
	function automatic ssrc_cnt_t ssrc_g2b(input ssrc_cnt_t g);
		ssrc_cnt_t b;
		b = g;
		for (int i = `SSRC_CNT_W - 2; i >= 0; i--)
			b[i] = b[i+1] ^ g[i];
		return b;
	endfunction
endpackage

// ===== ssrc_if.sv
// Serial link between host and device ends
`timescale 1ns/1ps
interface ssrc_if;
	logic sck;   // Serial clock, made by the host
	logic cs_n;  // Select, active low
	logic si;    // Host to device data
	logic so;    // Device to host data
	logic so_oe; // Device drives so while high

	// Host end
	modport host (
		output sck,
		output cs_n,
		output si,
		input  so,
		input  so_oe
	);

	// Device end
	modport device (
		input  sck,
		input  cs_n,
		input  si,
		output so,
		output so_oe
	);
endinterface

// ===== ssrc_device.sv
// Device end: sleep, wake and reset sequencing behind the serial link
`timescale 1ns/1ps
`include "ssrc_cfg.svh"
module ssrc_device #(
	parameter int unsigned TW        = 16,
	parameter int unsigned HWRST_CYC = ssrc_pkg::ssrc_cyc_dn(`SSRC_T_HWRST_NS),
	parameter int unsigned SOFT_RESET_CMD_CYC  = ssrc_pkg::ssrc_cyc_dn(`SSRC_T_SOFT_RESET_CMD_NS)
)(
	input  wire logic              sys_clk,
	input  wire logic              rst,
	ssrc_if.device                 link,
	input  wire logic              so_data,
	input  wire logic              so_en,
	input  wire logic              vol_wr,
	input  wire logic [7:0]        vol_wdata,
	output logic      [7:0]        vol_rdata,
	output logic                   asleep,
	output logic                   standby,
	output logic                   core_reset,
	output logic                   frame_valid,
	output logic      [7:0]        frame_op
);
	import ssrc_pkg::*;

	// Cycle counts derived from the times
	localparam int unsigned ENTRY_CYC = ssrc_cyc_dn(`SSRC_T_ENTRY_NS);
	localparam int unsigned EXIT_CYC  = ssrc_cyc_dn(`SSRC_T_EXIT_NS);
	localparam int unsigned WAKE_CYC  = ssrc_cyc_up(`SSRC_T_WAKE_NS);

	// Link side state, clocked by the serial clock
	// Two-state bits start at zero, since no reset reaches this domain
	typedef struct packed {
		bit [7:0]             shift; // Last eight bits taken in
		bit [`SSRC_CNT_W-1:0] gray;  // Running bit count, gray coded
	} ssrc_lnk_t;

	// Core side state, clocked by the system clock
	typedef struct packed {
		ssrc_dev_st_t   st;     // Power state
		logic           cs_m;   // Select sync, first stage
		logic           cs_s;   // Select sync, second stage
		logic           cs_p;   // Select, one cycle older
		logic           si_m;   // Data sync, first stage
		logic           si_s;   // Data sync, second stage
		ssrc_cnt_t      g_m;    // Bit count sync, first stage
		ssrc_cnt_t      g_s;    // Bit count sync, second stage
		logic [7:0]     op_m;   // Opcode sync, first stage
		logic [7:0]     op_s;   // Opcode sync, second stage
		ssrc_cnt_t      base;   // Bit count at frame start
		logic           si_lo;  // Data level at frame start
		logic [TW-1:0]  lo;     // Length of the low phase
		logic [1:0]     ev;     // Countdown to frame decode
		logic [3:0]     jh;     // Data levels of clockless pulses
		logic [2:0]     jn;     // Clockless pulses in a row
		logic [TW-1:0]  tmr;    // State timer
		logic [7:0]     vol;    // Volatile register bits
		logic           rst_p;  // Reset pulse to the core
		logic           frm_p;  // Frame pulse to the core
		logic [7:0]     frm_op; // Opcode of the last frame
	} ssrc_core_t;

	ssrc_lnk_t  ln_q;    // Link registers
	ssrc_lnk_t  ln_d;    // Link next value
	ssrc_core_t c_q;     // Core registers
	ssrc_core_t c_d;     // Core next value
	ssrc_cnt_t  nbits;   // Bits in the frame just ended
	logic       fall;    // Select went low
	logic       rise;    // Select went high
	logic       eval;    // Frame decode cycle
	logic       jhit;    // Clockless reset sequence complete
	logic       is_8;    // Frame held exactly one byte
	logic [3:0] jnext;   // Pulse history with this pulse

	// Link side: take a bit on each rising serial clock edge.
	// Edges only come while select is low, so no frame gate is needed,
	// and the count needs no reset because only differences are used.
	always_comb
	begin
		ln_d       = ln_q;
		ln_d.shift = {ln_q.shift[6:0], link.si};
		ln_d.gray  = ssrc_b2g(ssrc_g2b(ln_q.gray) + 1'b1);
	end

	// Link registers, loaded on each rising serial clock edge
	always_ff @(posedge link.sck)
	begin
		ln_q <= ln_d;
	end

	// Frame boundaries seen from the core side
	assign fall  = c_q.cs_p & ~c_q.cs_s;
	assign rise  = ~c_q.cs_p & c_q.cs_s;
	assign eval  = (c_q.ev == `SSRC_EVAL_NOW);
	assign nbits = ssrc_g2b(c_q.g_s) - c_q.base;
	assign is_8  = (nbits == `SSRC_BYTE_BITS);
	assign jnext = {c_q.jh[2:0], c_q.si_lo};
	// Fourth clockless pulse in a row with the right data levels
	assign jhit  = eval & (nbits == `SSRC_NO_BITS) & (jnext == `SSRC_JEDEC_PAT)
		& (c_q.jn >= `SSRC_JEDEC_PRIOR);

	// Core next state
	always_comb
	begin
		c_d       = c_q;
		// Synchronisers; first stages feed only second stages
		c_d.cs_m  = link.cs_n;
		c_d.cs_s  = c_q.cs_m;
		c_d.cs_p  = c_q.cs_s;
		c_d.si_m  = link.si;
		c_d.si_s  = c_q.si_m;
		// Count is gray coded, so a sample mid-change is off by one at most
		c_d.g_m   = ln_q.gray;
		c_d.g_s   = c_q.g_m;
		// Opcode is only used once the link has gone quiet
		c_d.op_m  = ln_q.shift;
		c_d.op_s  = c_q.op_m;
		c_d.rst_p = 1'b0;
		c_d.frm_p = 1'b0;
		// Frame start: mark count, data level, restart low timer
		if (fall)
		begin
			c_d.base  = ssrc_g2b(c_q.g_s);
			c_d.si_lo = c_q.si_s;
			c_d.lo    = '0;
		end
		// Low phase timer, saturating
		else if (!c_q.cs_s && (c_q.lo != {TW{1'b1}}))
		begin
			c_d.lo = c_q.lo + 1'b1;
		end
		// Wait for the last bit count to cross before decoding
		if (rise)
		begin
			c_d.ev = `SSRC_EVAL_WAIT;
		end
		else if (c_q.ev != 2'h0)
		begin
			c_d.ev = c_q.ev - 1'b1;
		end
		// Clockless pulse history; any clocked frame breaks the run
		if (eval)
		begin
			if (nbits == `SSRC_NO_BITS)
			begin
				c_d.jh = jnext;
				c_d.jn = (c_q.jn == 3'h7) ? c_q.jn : c_q.jn + 1'b1;
			end
			else
			begin
				c_d.jn = 3'h0;
			end
		end
		if (c_q.tmr != '0)
		begin
			c_d.tmr = c_q.tmr - 1'b1;
		end
		case (c_q.st)
			// Standby: decode finished frames
			D_ACTIVE:
			begin
				if (vol_wr)
				begin
					c_d.vol = vol_wdata;
				end
				if (jhit)
				begin
					c_d.st    = D_HWRST;
					c_d.tmr   = TW'(HWRST_CYC - 1);
					c_d.vol   = '0;
					c_d.rst_p = 1'b1;
					c_d.jn    = 3'h0;
				end
				// Only a one-byte enter opcode starts sleep
				else if (eval && is_8 && (c_q.op_s == `SSRC_OP_ENTER))
				begin
					c_d.st  = D_ENTERING;
					c_d.tmr = TW'(ENTRY_CYC - 1);
				end
				else if (eval && is_8 && (c_q.op_s == `SSRC_OP_SOFT_RESET_CMD))
				begin
					c_d.st    = D_SOFT_RESET_CMD;
					c_d.tmr   = TW'(SOFT_RESET_CMD_CYC - 1);
					c_d.vol   = '0;
					c_d.rst_p = 1'b1;
				end
				// Other clocked frames go on to the rest of the device
				else if (eval && (nbits != `SSRC_NO_BITS))
				begin
					c_d.frm_p  = 1'b1;
					c_d.frm_op = c_q.op_s;
				end
			end
			// Entry delay before low current
			D_ENTERING:
			begin
				if (c_q.tmr == '0)
				begin
					c_d.st = D_SLEEP;
				end
			end
			// Asleep: everything but a wake action is dropped
			D_SLEEP:
			begin
				if (eval && ((is_8 && (c_q.op_s == `SSRC_OP_EXIT))
					|| (c_q.lo >= TW'(WAKE_CYC - 1))))
				begin
					c_d.st  = D_WAKING;
					c_d.tmr = TW'(EXIT_CYC - 1);
				end
			end
			// Exit delay back to standby
			D_WAKING:
			begin
				if (c_q.tmr == '0)
				begin
					c_d.st = D_ACTIVE;
				end
			end
			// Reset completion
			D_SOFT_RESET_CMD, D_HWRST:
			begin
				if (c_q.tmr == '0)
				begin
					c_d.st = D_ACTIVE;
				end
			end
			default:
			begin
				c_d.st = D_ACTIVE;
			end
		endcase
		// Volatile bits are never touched by sleep states
	end

	// Core registers
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			c_q      <= '0;
			c_q.st   <= D_ACTIVE;
			c_q.cs_m <= 1'b1;
			c_q.cs_s <= 1'b1;
			c_q.cs_p <= 1'b1;
		end
		else
		begin
			c_q <= c_d;
		end
	end

	// Output driver; off unless in standby, so never while waking
	assign link.so    = so_data;
	assign link.so_oe = so_en & (c_q.st == D_ACTIVE);

	// User side
	assign vol_rdata   = c_q.vol;
	assign asleep      = (c_q.st == D_SLEEP);
	assign standby     = (c_q.st == D_ACTIVE);
	assign core_reset  = c_q.rst_p;
	assign frame_valid = c_q.frm_p;
	assign frame_op    = c_q.frm_op;
endmodule

// ===== ssrc_host.sv
// Host end: drives frames, wake pulses and reset pulses with gaps
`timescale 1ns/1ps
`include "ssrc_cfg.svh"
module ssrc_host #(
	parameter int unsigned TW        = 16,
	parameter int unsigned HWRST_CYC = ssrc_pkg::ssrc_cyc_up(`SSRC_T_HWRST_NS),
	parameter int unsigned SOFT_RESET_CMD_CYC  = ssrc_pkg::ssrc_cyc_up(`SSRC_T_SOFT_RESET_CMD_NS)
)(
	input  wire logic                sys_clk,
	input  wire logic                rst,
	ssrc_if.host                     link,
	input  wire logic                cmd_valid,
	input  wire ssrc_pkg::ssrc_kind_t cmd_kind,
	input  wire logic [7:0]          cmd_byte,
	output logic                     cmd_ready,
	output logic                     cmd_refused,
	output logic                     asleep,
	output logic                     busy
);
	import ssrc_pkg::*;

	// Least waits, rounded up
	localparam int unsigned HALF_CYC = `SSRC_SCK_HALF;
	localparam int unsigned ENTRY_CYC = ssrc_cyc_up(`SSRC_T_ENTRY_NS);
	localparam int unsigned EXIT_CYC  = ssrc_cyc_up(`SSRC_T_EXIT_NS);
	localparam int unsigned WAKE_CYC  = ssrc_cyc_up(`SSRC_T_WAKE_NS);
	localparam int unsigned RD_CYC    = ssrc_cyc_up(`SSRC_T_GAP_RD_NS);
	localparam int unsigned REG_CYC   = ssrc_cyc_up(`SSRC_T_GAP_REG_NS);
	localparam int unsigned ARR_CYC   = ssrc_cyc_up(`SSRC_T_GAP_ARR_NS);
	localparam int unsigned PH_CYC    = ssrc_cyc_up(`SSRC_T_RSTPH_NS);

	// All host state
	typedef struct packed {
		ssrc_host_st_t  st;   // Sequencer state
		ssrc_kind_t     kind; // Transaction under way
		logic [7:0]     sh;   // Bits still to send
		logic [3:0]     bits; // Count of bits left
		logic [2:0]     ph;   // Reset pulse phase
		logic [TW-1:0]  tmr;  // Phase timer
		logic           sck;  // Serial clock out
		logic           cs_n; // Select out
		logic           si;   // Data out
		logic           slp;  // Device believed asleep
		logic           ref_p; // Refusal pulse
	} ssrc_host_t;

	ssrc_host_t h_q; // Registers
	ssrc_host_t h_d; // Next value

	// Deselect time owed after each kind of transaction
	function automatic logic [TW-1:0] gap_of(input ssrc_kind_t k);
		case (k)
			K_READ:     return TW'(RD_CYC - 1);
			K_REG_WR:   return TW'(REG_CYC - 1);
			K_ARR_WR:   return TW'(ARR_CYC - 1);
			K_SLEEP:    return TW'(ENTRY_CYC - 1);
			K_SOFT_RST: return TW'(SOFT_RESET_CMD_CYC - 1);
			K_HW_RST:   return TW'(HWRST_CYC - 1);
			default:    return TW'(EXIT_CYC - 1);
		endcase
	endfunction

	// Opcode byte sent for each kind
	function automatic logic [7:0] op_of(input ssrc_kind_t k, input logic [7:0] b);
		case (k)
			K_SLEEP:    return `SSRC_OP_ENTER;
			K_WAKE_CMD: return `SSRC_OP_EXIT;
			K_SOFT_RST: return `SSRC_OP_SOFT_RESET_CMD;
			default:    return b;
		endcase
	endfunction

	// Sequencer next state
	always_comb
	begin
		logic [2:0] nph;
		logic [2:0] nxt;
		h_d       = h_q;
		h_d.ref_p = 1'b0;
		nph       = h_q.ph + 1'b1;
		nxt       = nph + 1'b1;
		if (h_q.tmr != '0)
		begin
			h_d.tmr = h_q.tmr - 1'b1;
		end
		case (h_q.st)
			// Wait for a request
			H_IDLE:
			begin
				if (cmd_valid)
				begin
					// Asleep: only wake actions go out
					if (h_q.slp && (cmd_kind != K_WAKE_CMD) && (cmd_kind != K_WAKE_PULSE))
					begin
						h_d.ref_p = 1'b1;
					end
					else if (cmd_kind == K_WAKE_PULSE)
					begin
						h_d.kind = cmd_kind;
						h_d.st   = H_PULSE;
						h_d.cs_n = 1'b0;
						h_d.tmr  = TW'(WAKE_CYC - 1);
					end
					else if (cmd_kind == K_HW_RST)
					begin
						h_d.kind = cmd_kind;
						h_d.st   = H_PULSE;
						h_d.cs_n = 1'b0;
						h_d.si   = 1'b0;
						h_d.ph   = 3'h0;
						h_d.tmr  = TW'(PH_CYC - 1);
					end
					else
					begin
						h_d.kind = cmd_kind;
						h_d.st   = H_SHIFT;
						h_d.cs_n = 1'b0;
						h_d.sh   = op_of(cmd_kind, cmd_byte);
						h_d.si   = h_d.sh[7];
						h_d.bits = 4'h8;
						h_d.tmr  = TW'(HALF_CYC - 1);
					end
				end
			end
			// One byte, most significant bit first
			H_SHIFT:
			begin
				if (h_q.tmr == '0)
				begin
					h_d.tmr = TW'(HALF_CYC - 1);
					if (!h_q.sck && (h_q.bits == 4'h0))
					begin
						// Select rises right after bit eight
						h_d.cs_n = 1'b1;
						h_d.st   = H_GAP;
						h_d.tmr  = gap_of(h_q.kind);
						if (h_q.kind == K_SLEEP)
						begin
							h_d.slp = 1'b1;
						end
						if (h_q.kind == K_WAKE_CMD)
						begin
							h_d.slp = 1'b0;
						end
					end
					else if (!h_q.sck)
					begin
						h_d.sck  = 1'b1;
						h_d.bits = h_q.bits - 1'b1;
					end
					else
					begin
						h_d.sck = 1'b0;
						h_d.sh  = {h_q.sh[6:0], 1'b0};
						h_d.si  = h_q.sh[6];
					end
				end
			end
			// Clockless select pulses
			H_PULSE:
			begin
				if (h_q.tmr == '0)
				begin
					if (h_q.kind == K_WAKE_PULSE)
					begin
						h_d.cs_n = 1'b1;
						h_d.st   = H_GAP;
						h_d.tmr  = gap_of(h_q.kind);
						h_d.slp  = 1'b0;
					end
					else if (h_q.ph == `SSRC_RST_LAST_PH)
					begin
						h_d.st  = H_GAP;
						h_d.tmr = gap_of(h_q.kind);
						h_d.slp = 1'b0;
					end
					else
					begin
						// Low and high phases alternate; data set ahead of next low
						h_d.ph   = nph;
						h_d.cs_n = nph[0];
						h_d.tmr  = TW'(PH_CYC - 1);
						if (nph[0])
						begin
							h_d.si = nxt[1];
						end
					end
				end
			end
			// Deselect gap before the next request
			H_GAP:
			begin
				if (h_q.tmr == '0)
				begin
					h_d.st = H_IDLE;
				end
			end
			default:
			begin
				h_d.st = H_IDLE;
			end
		endcase
	end

	// Registers
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			h_q      <= '0;
			h_q.st   <= H_IDLE;
			h_q.kind <= K_READ;
			h_q.cs_n <= 1'b1;
		end
		else
		begin
			h_q <= h_d;
		end
	end

	// Link pins
	assign link.sck  = h_q.sck;
	assign link.cs_n = h_q.cs_n;
	assign link.si   = h_q.si;

	// User side
	assign cmd_ready   = (h_q.st == H_IDLE);
	assign cmd_refused = h_q.ref_p;
	assign asleep      = h_q.slp;
	assign busy        = (h_q.st != H_IDLE);
endmodule

// ===== ssrc_assertions.sv
// Link-side checks of the sleep, wake and reset sequencing
`timescale 1ns/1ps
`include "ssrc_cfg.svh"
module ssrc_assertions #(
	parameter int SOFT_RESET_CMD_CYC = 40
)(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic si,
	input wire logic so,
	input wire logic so_oe
);
	localparam int SR_LO = SOFT_RESET_CMD_CYC;
	localparam int SR_HI = SOFT_RESET_CMD_CYC + 40;
	logic       sck_q, cs_q, slp_q; // Edge history, sleep seen
	logic [7:0] sh_q, bc_q, lc_q;   // Bits, bit count, low time
	logic [8:0] ec_q;               // Cycles since sleep entry
	logic       rise, ent, wk, sr;  // Frame end events
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// Decode frame ends from the wire alone
	assign rise = cs_n && !cs_q;
	assign ent  = rise && !slp_q && bc_q == 8'h08 && sh_q == `SSRC_OP_ENTER;
	assign wk   = rise && slp_q && ((bc_q == 8'h08 && sh_q == `SSRC_OP_EXIT) || (bc_q == 8'h00 && lc_q >= 8'h64));
	assign sr   = rise && !slp_q && bc_q == 8'h08 && sh_q == `SSRC_OP_SOFT_RESET_CMD;
	// Shadow of the device state; bit count wraps, low time and entry counters saturate
	always_ff @(posedge sys_clk)
	begin
		sck_q <= sck;
		cs_q  <= rst ? 1'b1 : cs_n;
		if (rst)
		begin
			sh_q  <= 8'h00;
			bc_q  <= 8'h00;
			lc_q  <= 8'h00;
			slp_q <= 1'b0;
			ec_q  <= 9'h000;
		end
		else
		begin
			if (!cs_n && sck && !sck_q)
			begin
				sh_q <= {sh_q[6:0], si};
				bc_q <= bc_q + 8'h01;
			end
			else if (cs_n)
				bc_q <= 8'h00;
			lc_q  <= cs_n ? 8'h00 : ((lc_q == 8'hFF) ? lc_q : lc_q + 8'h01);
			slp_q <= ent ? 1'b1 : (wk ? 1'b0 : slp_q);
			ec_q  <= ent ? 9'h000 : ((ec_q == 9'h190) ? ec_q : ec_q + 9'h001);
		end
	end
	a_sck_idle_low: assert property (cs_n |-> !sck)
		else $error("serial clock moved while deselected");
	a_sck_high_len: assert property ($rose(sck) |-> sck[*8] ##1 !sck)
		else $error("serial clock high phase wrong");
	a_si_steady: assert property (sck |-> $stable(si))
		else $error("data moved while clock high");
	a_read_gap: assert property ($rose(cs_n) |-> cs_n[*2])
		else $error("deselect gap too short");
	a_sleep_off: assert property (ent |-> ##[300:320] !so_oe)
		else $error("output still on after sleep entry");
	a_asleep_quiet: assert property (slp_q && ec_q >= 9'h140 |-> !so_oe)
		else $error("output driven while asleep");
	a_wake_quiet: assert property (wk |-> !so_oe[*8])
		else $error("output driven while waking");
	a_wake_ready: assert property (wk |-> ##[300:330] so_oe)
		else $error("standby not back after wake");
	a_soft_reset_cmd_off: assert property (sr |-> ##10 !so_oe)
		else $error("soft reset did not start");
	a_soft_reset_cmd_done: assert property (sr |-> ##[SR_LO:SR_HI] so_oe)
		else $error("soft reset too long");
	c_enter: cover property (ent);
	c_wake: cover property (wk);
	c_soft_reset_cmd: cover property (sr);
endmodule

// ===== serial_memory_sleep_reset_control_test.sv
// Both link ends joined, plus a bench-driven device for faults
`timescale 1ns/1ps
`include "ssrc_cfg.svh"
module serial_memory_sleep_reset_control_test;
	import ssrc_pkg::*;
	logic       sys_clk, rst, cmd_valid, cmd_ready, cmd_refused;
	ssrc_kind_t cmd_kind;                     // Host request kind
	logic [7:0] cmd_byte, vol_wdata, vol_rdata, frame_op, f_vol, fv_op;
	logic       so_data, so_en, vol_wr, core_reset, frame_valid;
	logic       d_asleep, h_asleep, standby, f_asleep, f_standby;
	logic       sck_q = 1'b0;                 // Serial clock, one cycle older
	logic [7:0] lk_sh = 8'h00, lk_n = 8'h00;  // Bits seen on the wire
	int         err_total = 0, n_compared = 0, cr_n = 0, ref_n = 0, n;
	int         hi_n = 0, lo_n = 0, last_hi = 0, last_lo = 0;
	ssrc_kind_t kd[3] = '{K_READ, K_REG_WR, K_ARR_WR};
	logic [7:0] ob[3] = '{8'h3C, 8'h5A, 8'hC3};
	int         gp[3] = '{`SSRC_T_GAP_RD_NS / `SSRC_CLK_NS, `SSRC_T_GAP_REG_NS / `SSRC_CLK_NS,
		`SSRC_T_GAP_ARR_NS / `SSRC_CLK_NS};
	// Fault table: frame bits, bit count, extra low time, asleep after
	logic [15:0] fv[7] = '{{`SSRC_OP_ENTER, 8'h00}, 16'h5A00, {`SSRC_OP_ENTER, 8'h00},
		{`SSRC_OP_SOFT_RESET_CMD, 8'h00}, {`SSRC_OP_EXIT, 8'h00}, 16'h0000, 16'h0000};
	int         fn[7] = '{9, 8, 8, 4, 5, 0, 0}; // Short frames stay under the wake pulse width
	int         fl[7] = '{0, 0, 0, 0, 0, 50, 120};
	logic       fa[7] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
	ssrc_if lnk();  // Host to device link
	ssrc_if flt();  // Bench to second device
	ssrc_host #(.HWRST_CYC(80), .SOFT_RESET_CMD_CYC(60)) u_ssrc_host (.sys_clk(sys_clk), .rst(rst), .link(lnk.host),
		.cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_byte(cmd_byte), .cmd_ready(cmd_ready),
		.cmd_refused(cmd_refused), .asleep(h_asleep), .busy());
	ssrc_device #(.HWRST_CYC(60), .SOFT_RESET_CMD_CYC(40)) u_ssrc_device (.sys_clk(sys_clk), .rst(rst),
		.link(lnk.device), .so_data(so_data), .so_en(so_en), .vol_wr(vol_wr), .vol_wdata(vol_wdata),
		.vol_rdata(vol_rdata), .asleep(d_asleep), .standby(standby), .core_reset(core_reset),
		.frame_valid(frame_valid), .frame_op(frame_op));
	ssrc_device u_ssrc_device_fault (.sys_clk(sys_clk), .rst(rst),
		.link(flt.device), .so_data(so_data), .so_en(so_en), .vol_wr(vol_wr), .vol_wdata(vol_wdata),
		.vol_rdata(f_vol), .asleep(f_asleep), .standby(f_standby), .core_reset(), .frame_valid(),
		.frame_op());
	ssrc_assertions #(.SOFT_RESET_CMD_CYC(40)) u_ssrc_assertions (.sys_clk(sys_clk), .rst(rst), .sck(lnk.sck),
		.cs_n(lnk.cs_n), .si(lnk.si), .so(lnk.so), .so_oe(lnk.so_oe));
	// Free-running system clock
	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	// Wire monitor: select phases, bits, pulses
	always @(posedge sys_clk)
	begin
		sck_q <= lnk.sck;
		if (core_reset === 1'b1)
			cr_n <= cr_n + 1;
		if (cmd_refused === 1'b1)
			ref_n <= ref_n + 1;
		if (frame_valid === 1'b1)
			fv_op <= frame_op;
		if (lnk.cs_n)
		begin
			hi_n <= hi_n + 1;
			lo_n <= 0;
			if (lo_n != 0)
				last_lo <= lo_n;
		end
		else
		begin
			lo_n <= lo_n + 1;
			hi_n <= 0;
			if (hi_n != 0)
			begin
				last_hi <= hi_n;
				lk_n    <= 8'h00;
			end
			else if (lnk.sck && !sck_q)
			begin
				lk_sh <= {lk_sh[6:0], lnk.si};
				lk_n  <= lk_n + 8'h01;
			end
		end
	end
	// Compare and count
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			err_total++;
			$display("ERROR %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask
	// Verdict and end of run
	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Host idle, bounded; a timeout ends the run as a failure
	task automatic idle();
		int k;
		k = 0;
		@(negedge sys_clk);
		while (cmd_ready !== 1'b1 && k < 20000)
		begin
			@(negedge sys_clk);
			k++;
		end
		if (k >= 20000)
		begin
			err_total++;
			stop_test();
		end
	endtask
	// One host request, valid for one cycle once the host is idle
	task automatic cmd(input ssrc_kind_t k, input logic [7:0] b);
		idle();
		@(posedge sys_clk);
		cmd_valid <= 1'b1;
		cmd_kind  <= k;
		cmd_byte  <= b;
		@(posedge sys_clk);
		cmd_valid <= 1'b0;
		idle();
		repeat (20) @(negedge sys_clk);
	endtask
	// Volatile write from the core side
	task automatic vw(input logic [7:0] v);
		@(posedge sys_clk);
		vol_wr    <= 1'b1;
		vol_wdata <= v;
		@(posedge sys_clk);
		vol_wr    <= 1'b0;
	endtask
	// Bench frame on the fault link; released data inverts
	task automatic ff(input logic [15:0] v, input int nb, input int lw);
		@(posedge sys_clk);
		flt.cs_n <= 1'b0;
		for (int j = 0; j < nb; j++)
		begin
			flt.si <= v[15-j];
			repeat (8) @(posedge sys_clk);
			flt.sck <= 1'b1;
			repeat (8) @(posedge sys_clk);
			flt.sck <= 1'b0;
		end
		repeat (8 + lw) @(posedge sys_clk);
		flt.cs_n <= 1'b1;
		flt.si   <= ~flt.si;
		repeat (400) @(posedge sys_clk);
	endtask
	// Main sequence
	initial
	begin
		{rst, so_data, so_en, cmd_valid, vol_wr, flt.sck, flt.si} = 7'b1110000;
		{cmd_byte, vol_wdata} = 16'h0;
		cmd_kind = K_READ;
		flt.cs_n = 1'b1;
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		@(negedge sys_clk);
		chk("idle_link", {lnk.cs_n, lnk.sck, standby, d_asleep}, 4'hA);
		vw(8'hA5);
		for (int i = 0; i < 3; i++)
		begin
			cmd(kd[i], ob[i]);
			chk("frame_op", fv_op, ob[i]);
			chk("wire_bits", {lk_n, lk_sh}, {8'h08, ob[i]});
			chk("no_sleep", d_asleep, 1'b0);
			cmd(K_READ, 8'h00);
			chk("gap", last_hi >= gp[i] + 20, 1'b1);
		end
		cmd(K_SLEEP, `SSRC_OP_ENTER);
		chk("asleep", {d_asleep, h_asleep, lnk.so_oe}, 3'b110);
		n = ref_n;
		cmd(K_READ, 8'h11);
		chk("refused", ref_n, n + 1);
		vw(8'h00);
		chk("vol_sleep", vol_rdata, 8'hA5);
		cmd(K_WAKE_CMD, `SSRC_OP_EXIT);
		chk("wake_cmd", {d_asleep, h_asleep, standby, vol_rdata}, {3'b001, 8'hA5});
		cmd(K_SLEEP, `SSRC_OP_ENTER);
		cmd(K_WAKE_PULSE, 8'h00);
		chk("wake_pulse", {d_asleep, standby, last_lo >= 100}, 3'b011);
		n = cr_n;
		cmd(K_SOFT_RST, `SSRC_OP_SOFT_RESET_CMD);
		chk("soft_rst", {cr_n == n + 1, standby, vol_rdata}, {2'b11, 8'h00});
		vw(8'h5A);
		n = cr_n;
		cmd(K_HW_RST, 8'h00);
		chk("hw_rst", {cr_n == n + 1, standby, vol_rdata}, {2'b11, 8'h00});
		chk("hw_phases", {last_lo >= 100, last_hi >= 100}, 2'b11);
		for (int i = 0; i < 7; i++)
		begin
			ff(fv[i], fn[i], fl[i]);
			chk("fault_asleep", {f_asleep, f_standby}, {fa[i], ~fa[i]});
		end
		chk("fault_vol", f_vol, 8'h5A);
		stop_test();
	end
endmodule
